//--- verilog/tts_pkg.sv
// Purpose: constants and types for the transfer trigger and status block
// Assumes: apb3 register access, 32-bit data, one clock
// Notes:   offsets are byte addresses, one aligned word per register
package tts_pkg;

  // sizes
  localparam int TTS_TYPES = 8;
  localparam int TTS_SRCS  = 32;

  // register byte offsets
  localparam logic [7:0] OFS_TYPE_SEL   = 8'h00;
  localparam logic [7:0] OFS_TRIG_CFG   = 8'h04;
  localparam logic [7:0] OFS_QUERY_SEL  = 8'h08;
  localparam logic [7:0] OFS_STATE      = 8'h0C;
  localparam logic [7:0] OFS_CMD        = 8'h10;
  localparam logic [7:0] OFS_HOST_PULSE = 8'h14;

  // field positions
  localparam int CFG_EN_BIT     = 0;
  localparam int CFG_ORIGIN_LSB = 8;
  localparam int CFG_QUAL_LSB   = 16;
  localparam int STATE_FLAG_BIT = 0;
  localparam int STATE_ALL_LSB  = 8;
  localparam int CMD_START      = 0;
  localparam int CMD_STOP       = 1;
  localparam int CMD_ABORT      = 2;
  localparam int CMD_PAUSE      = 3;
  localparam int CMD_RESUME     = 4;

  // trigger type codes
  localparam logic [2:0] TYP_START    = 3'h0;
  localparam logic [2:0] TYP_STOP     = 3'h1;
  localparam logic [2:0] TYP_ABORT    = 3'h2;
  localparam logic [2:0] TYP_PAUSE    = 3'h3;
  localparam logic [2:0] TYP_RESUME   = 3'h4;
  localparam logic [2:0] TYP_ACTIVATE = 3'h5;
  localparam logic [2:0] TYP_BURST_GO = 3'h6;
  localparam logic [2:0] TYP_BURST_END = 3'h7;

  // qualification codes
  localparam logic [2:0] QUAL_RISE = 3'h0;
  localparam logic [2:0] QUAL_FALL = 3'h1;
  localparam logic [2:0] QUAL_BOTH = 3'h2;
  localparam logic [2:0] QUAL_HIGH = 3'h3;
  localparam logic [2:0] QUAL_LOW  = 3'h4;

  // status query codes
  localparam logic [2:0] QRY_STREAMING = 3'h0;
  localparam logic [2:0] QRY_PAUSED    = 3'h1;
  localparam logic [2:0] QRY_STOPPING  = 3'h2;
  localparam logic [2:0] QRY_STOPPED   = 3'h3;
  localparam logic [2:0] QRY_OVERRUN   = 3'h4;

  typedef struct packed {
    logic       en;
    logic [4:0] origin;
    logic [2:0] qual;
  } tts_cfg_t;

  // external trigger sources, four units of each kind
  typedef struct packed {
    logic [3:0] bus_command;
    logic [3:0] comb_gate_out;
    logic [3:0] interval_unit_finish;
    logic [3:0] interval_unit_begin;
    logic [3:0] count_unit_finish;
    logic [3:0] count_unit_begin;
    logic [3:0] io_pin;
  } tts_src_t;

  typedef struct packed {
    logic streaming;
    logic paused;
    logic stopping;
    logic stopped;
    logic overrun;
  } tts_flags_t;

  typedef enum logic [1:0] {st_stopped, st_streaming, st_stopping, st_paused} tts_state_t;

  // reset values
  localparam logic [2:0] RST_TYPE_SEL  = 3'h0;
  localparam logic [2:0] RST_QUERY_SEL = 3'h0;
  localparam tts_cfg_t   RST_CFG       = '{en: 1'b0, origin: 5'h00, qual: QUAL_RISE};

endpackage : tts_pkg

//--- verilog/tts_top.sv
// Purpose: trigger qualification, transfer state and status readback
// Assumes: apb3 slave with one wait state, sources synchronised here
// Notes:   queue, burst counting and transport live outside this block
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

// Functional notes
// RULE1: each trigger type has an enable; when off its source is ignored.
// RULE2: an io pin may be chosen as the trigger source.
// RULE3: a counter begin or finish event may be the trigger source.
// RULE4: a timer begin or finish event may be the trigger source.
// RULE5: a logic block output may be the trigger source.
// RULE6: a software pulse may be the trigger source.
// RULE7: an action command may be the trigger source.
// RULE8: rising mode fires only on a low to high change.
// RULE9: falling mode fires only on a high to low change.
// RULE10: both-edge mode fires on every change of the source.
// RULE11: level-high mode is asserted while the source stays high.
// RULE12: level-low mode is asserted while the source stays low.
// RULE13: level modes only for activate and pause; others stay edge-qualified.
// RULE14: while streaming, each block is sent once its data is ready.
// RULE15: stop enters stopping, finishes current block, then goes stopped.
// RULE16: no blocks are sent while stopped.
// RULE17: pause suspends transmission at once and reports paused.
// RULE18: queue overflow is reported while the queue overflows.
// RULE19: the selected status condition reads back as one bit.
// RULE20: eight trigger types, each with its own enable, source and mode.
// RULE21: every source is synchronised before qualification.
module tts_top
  import tts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire tts_src_t    src,
  input  wire logic        block_ready,
  input  wire logic        block_done,
  input  wire logic        block_store_overrun,
  output logic             block_send,
  output logic             xfer_hold,
  output logic             block_flush,
  output logic [7:0]       trig_event,
  output tts_flags_t       status_flags,
  output logic             xfer_state_flag
);

  // decode of mapped offsets, used for the error answer; the read mux has its own case
  function automatic logic tts_mapped(input logic [7:0] a);
    case (a)
      OFS_TYPE_SEL, OFS_TRIG_CFG, OFS_QUERY_SEL,
      OFS_STATE, OFS_CMD, OFS_HOST_PULSE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : tts_mapped

  // edge or level qualification of one source
  function automatic logic tts_qualify(input logic [2:0] q, input logic cur, input logic prv);
    case (q)
      QUAL_RISE: return cur & ~prv; // RULE8
      QUAL_FALL: return ~cur & prv; // RULE9
      QUAL_BOTH: return cur ^ prv;  // RULE10
      QUAL_HIGH: return cur;        // RULE11
      QUAL_LOW:  return ~cur;       // RULE12
      default:   return 1'b0;
    endcase
  endfunction : tts_qualify

  // level modes are coerced to rising for types that cannot hold a level
  function automatic logic [2:0] tts_legal_qual(input logic [2:0] t, input logic [2:0] q);
    if (q > QUAL_LOW)
      return QUAL_RISE;
    if (q >= QUAL_HIGH && t != TYP_PAUSE && t != TYP_ACTIVATE)
      return QUAL_RISE; // RULE13
    return q;
  endfunction : tts_legal_qual

  // pick one status flag by query code
  function automatic logic tts_pick(input tts_flags_t f, input logic [2:0] s);
    case (s)
      QRY_STREAMING: return f.streaming;
      QRY_PAUSED:    return f.paused;
      QRY_STOPPING:  return f.stopping;
      QRY_STOPPED:   return f.stopped;
      QRY_OVERRUN:   return f.overrun;
      default:       return 1'b0;
    endcase
  endfunction : tts_pick

  logic [2:0]          xfer_trig_type_sel;
  logic [2:0]          xfer_state_query_sel;
  tts_cfg_t            cfg [TTS_TYPES];
  logic [4:0]          cmd;
  logic [3:0]          host_pulse;
  logic [TTS_SRCS-1:0] src_all;
  logic [TTS_SRCS-1:0] sync1;
  logic [TTS_SRCS-1:0] sync2;
  logic [TTS_SRCS-1:0] sync3;
  logic [7:0]          hit;
  logic [7:0]          sel_cur;
  logic [7:0]          sel_prv;
  tts_state_t          state;
  tts_state_t          next_state;
  tts_flags_t          next_flags;
  logic                busy;
  logic                send_now;
  logic                wr_en;
  logic                rd_take;
  logic [31:0]         rd_mux;
  logic                start_req;
  logic                stop_req;
  logic                abort_req;
  logic                pause_req;
  logic                resume_req;
  logic                pause_lvl;
  logic                act_lvl;
  logic                act_ok;

  // apb handshake: one wait state, write lands at the pready edge
  assign wr_en   = psel & penable & pready & pwrite;
  assign rd_take = psel & penable & ~pready;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_take;
      pslverr <= rd_take & ~tts_mapped(paddr);
    end
  end

  // read data mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_TYPE_SEL:  rd_mux[2:0] = xfer_trig_type_sel;
      OFS_TRIG_CFG: begin
        rd_mux[CFG_EN_BIT]          = cfg[xfer_trig_type_sel].en;
        rd_mux[CFG_ORIGIN_LSB +: 5] = cfg[xfer_trig_type_sel].origin;
        rd_mux[CFG_QUAL_LSB +: 3]   = cfg[xfer_trig_type_sel].qual;
      end
      OFS_QUERY_SEL: rd_mux[2:0] = xfer_state_query_sel;
      OFS_STATE: begin
        rd_mux[STATE_FLAG_BIT]     = tts_pick(next_flags, xfer_state_query_sel); // RULE19
        rd_mux[STATE_ALL_LSB +: 5] = next_flags;
      end
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (rd_take && !pwrite)
      prdata <= rd_mux;
  end

  // selectors
  always_ff @(posedge clk) begin
    if (!rstn) begin
      xfer_trig_type_sel   <= RST_TYPE_SEL;
      xfer_state_query_sel <= RST_QUERY_SEL;
    end else if (wr_en) begin
      if (paddr == OFS_TYPE_SEL)
        xfer_trig_type_sel <= pwdata[2:0];
      if (paddr == OFS_QUERY_SEL)
        xfer_state_query_sel <= pwdata[2:0];
    end
  end

  // per-type configuration, written through the type selector
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < TTS_TYPES; i++)
        cfg[i] <= RST_CFG;
    end else if (wr_en && paddr == OFS_TRIG_CFG) begin
      cfg[xfer_trig_type_sel].en     <= pwdata[CFG_EN_BIT];                    // RULE1
      cfg[xfer_trig_type_sel].origin <= pwdata[CFG_ORIGIN_LSB +: 5];           // RULE20
      cfg[xfer_trig_type_sel].qual   <= tts_legal_qual(xfer_trig_type_sel,
                                          pwdata[CFG_QUAL_LSB +: 3]);          // RULE13
    end
  end

  // command and software pulses last one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd        <= 5'h00;
      host_pulse <= 4'h0;
    end else begin
      cmd        <= (wr_en && paddr == OFS_CMD) ? pwdata[4:0] : 5'h00;
      host_pulse <= (wr_en && paddr == OFS_HOST_PULSE) ? pwdata[3:0] : 4'h0; // RULE6
    end
  end

  // source vector: index bits [4:2] pick the kind, [1:0] the unit
  assign src_all = {src.bus_command,          // RULE7
                    host_pulse,               // RULE6
                    src.comb_gate_out,        // RULE5
                    src.interval_unit_finish, // RULE4
                    src.interval_unit_begin,  // RULE4
                    src.count_unit_finish,    // RULE3
                    src.count_unit_begin,     // RULE3
                    src.io_pin};              // RULE2

  // two-stage synchroniser plus a history stage for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= src_all; // RULE21
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // history is kept per source, so changing the origin cannot fake an edge
  genvar g;
  generate
    for (g = 0; g < TTS_TYPES; g++) begin : g_trig
      assign sel_cur[g] = sync2[cfg[g].origin];
      assign sel_prv[g] = sync3[cfg[g].origin];
      assign hit[g]     = cfg[g].en & tts_qualify(cfg[g].qual, sel_cur[g], sel_prv[g]); // RULE1
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn)
      trig_event <= 8'h00;
    else
      trig_event <= hit;
  end

  // requests from triggers and software commands
  assign pause_lvl  = cfg[TYP_PAUSE].en & (cfg[TYP_PAUSE].qual >= QUAL_HIGH);
  assign act_lvl    = cfg[TYP_ACTIVATE].en & (cfg[TYP_ACTIVATE].qual >= QUAL_HIGH);
  assign act_ok     = ~act_lvl | hit[TYP_ACTIVATE];                             // RULE11
  assign start_req  = hit[TYP_START] | cmd[CMD_START] | (hit[TYP_ACTIVATE] & ~act_lvl);
  assign stop_req   = hit[TYP_STOP] | cmd[CMD_STOP];
  assign abort_req  = hit[TYP_ABORT] | cmd[CMD_ABORT];
  assign pause_req  = (hit[TYP_PAUSE] & ~pause_lvl) | cmd[CMD_PAUSE];
  assign resume_req = hit[TYP_RESUME] | cmd[CMD_RESUME];

  // transfer state: abort beats stop beats pause, resume and start
  always_comb begin
    next_state = state;
    case (state)
      st_stopped: begin
        if (!abort_req && !stop_req && start_req)
          next_state = st_streaming;
      end
      st_streaming: begin
        if (abort_req)
          next_state = st_stopped;
        else if (stop_req)
          next_state = (busy && !block_done) ? st_stopping : st_stopped; // RULE15
        else if (pause_req || (pause_lvl && hit[TYP_PAUSE]))
          next_state = st_paused;                                         // RULE17
      end
      st_stopping: begin
        if (abort_req || !busy || block_done)
          next_state = st_stopped;                                        // RULE15
      end
      st_paused: begin
        if (abort_req)
          next_state = st_stopped;
        else if (stop_req)
          next_state = (busy && !block_done) ? st_stopping : st_stopped;
        else if (pause_lvl ? !hit[TYP_PAUSE] : resume_req)
          next_state = st_streaming;
      end
      default: next_state = st_stopped;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      state <= st_stopped;
    else
      state <= next_state;
  end

  // a new block goes out only while streaming stays streaming
  assign send_now = (state == st_streaming) & (next_state == st_streaming) &
                    block_ready & ~busy & ~block_send & act_ok; // RULE14

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy        <= 1'b0;
      block_send  <= 1'b0;
      block_flush <= 1'b0;
    end else begin
      block_send  <= send_now; // RULE16
      block_flush <= abort_req & (state != st_stopped);
      if (abort_req)
        busy <= 1'b0;
      else if (send_now)
        busy <= 1'b1;
      else if (block_done)
        busy <= 1'b0;
    end
  end

  // status flags follow the next state so they match the state register
  always_comb begin
    next_flags           = '0;
    next_flags.streaming = (next_state == st_streaming);
    next_flags.paused    = (next_state == st_paused);
    next_flags.stopping  = (next_state == st_stopping);
    next_flags.stopped   = (next_state == st_stopped);
    next_flags.overrun   = block_store_overrun; // RULE18
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_flags    <= '{streaming: 1'b0, paused: 1'b0, stopping: 1'b0, stopped: 1'b1, overrun: 1'b0};
      xfer_state_flag <= 1'b0;
      xfer_hold       <= 1'b0;
    end else begin
      status_flags    <= next_flags;
      xfer_state_flag <= tts_pick(next_flags, xfer_state_query_sel); // RULE19
      xfer_hold       <= (next_state == st_paused);                  // RULE17
    end
  end

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!rstn) // RULE1
    !cfg[TYP_START].en |=> !trig_event[TYP_START])
    else $error("disabled trigger produced an event");

  a_rise_only: assert property (@(posedge clk) disable iff (!rstn) // RULE8
    (cfg[TYP_BURST_GO].en && cfg[TYP_BURST_GO].qual == QUAL_RISE) |->
      (hit[TYP_BURST_GO] == (sel_cur[TYP_BURST_GO] && !sel_prv[TYP_BURST_GO])))
    else $error("rising mode mismatch");

  a_fall_only: assert property (@(posedge clk) disable iff (!rstn) // RULE9
    (cfg[TYP_BURST_GO].en && cfg[TYP_BURST_GO].qual == QUAL_FALL &&
     !sel_cur[TYP_BURST_GO] && sel_prv[TYP_BURST_GO])
      |=> trig_event[TYP_BURST_GO])
    else $error("falling edge not seen");

  a_both_edges: assert property (@(posedge clk) disable iff (!rstn) // RULE10
    (cfg[TYP_BURST_GO].en && cfg[TYP_BURST_GO].qual == QUAL_BOTH &&
     (sel_cur[TYP_BURST_GO] != sel_prv[TYP_BURST_GO]))
      |=> trig_event[TYP_BURST_GO])
    else $error("any edge not seen");

  a_level_high: assert property (@(posedge clk) disable iff (!rstn) // RULE11
    (cfg[TYP_PAUSE].en && cfg[TYP_PAUSE].qual == QUAL_HIGH) |-> (hit[TYP_PAUSE] == sel_cur[TYP_PAUSE]))
    else $error("level high mismatch");

  a_level_low: assert property (@(posedge clk) disable iff (!rstn) // RULE12
    (cfg[TYP_ACTIVATE].en && cfg[TYP_ACTIVATE].qual == QUAL_LOW) |->
      (hit[TYP_ACTIVATE] == !sel_cur[TYP_ACTIVATE]))
    else $error("level low mismatch");

  a_edge_only_types: assert property (@(posedge clk) disable iff (!rstn) // RULE13
    cfg[TYP_STOP].qual <= QUAL_BOTH && cfg[TYP_START].qual <= QUAL_BOTH && cfg[TYP_BURST_GO].qual <= QUAL_BOTH)
    else $error("level mode on edge-only type");

  a_send_cause: assert property (@(posedge clk) disable iff (!rstn) // RULE14
    $rose(block_send) |-> $past(block_ready) && $past(state) == st_streaming)
    else $error("block sent without cause");

  a_stopped_silent: assert property (@(posedge clk) disable iff (!rstn) // RULE16
    (state == st_stopped) |=> !block_send)
    else $error("block sent while stopped");

  a_stop_drains: assert property (@(posedge clk) disable iff (!rstn) // RULE15
    (state == st_stopping && !abort_req && busy && !block_done) |=> (state == st_stopping) && !block_send)
    else $error("stopping left before block end");

  a_pause_now: assert property (@(posedge clk) disable iff (!rstn) // RULE17
    (state == st_streaming && pause_req && !abort_req && !stop_req) |=> xfer_hold && status_flags.paused)
    else $error("pause not immediate");

  a_overrun_flag: assert property (@(posedge clk) disable iff (!rstn) // RULE18
    block_store_overrun |=> status_flags.overrun)
    else $error("overrun not reported");

  a_status_read: assert property (@(posedge clk) disable iff (!rstn) // RULE19
    (rd_take && !pwrite && paddr == OFS_STATE) |=> pready && prdata[STATE_FLAG_BIT] == xfer_state_flag)
    else $error("status readback differs");

  a_sync_latency: assert property (@(posedge clk) disable iff (!rstn) // RULE21
    $rose(src.io_pin[0]) |-> ##2 sync2[0])
    else $error("synchroniser latency wrong");

endmodule : tts_top

//--- sim/tts_queue_model.sv
// Purpose: block queue and sender on the far side of the transfer block
// Assumes: one clock, block_ready follows have_data, lat sets block length
// Notes:   a held block never finishes, so pause stalls block_done
`timescale 1ns/1ps
module tts_queue_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       block_send,
  input  wire logic       xfer_hold,
  input  wire logic       block_flush,
  input  wire logic       have_data,
  input  wire logic       overflow,
  input  wire logic [7:0] lat,
  output logic            block_ready,
  output logic            block_done,
  output logic            block_store_overrun
);
  logic       busy;
  logic [7:0] cnt;

  // queue levels straight from the bench
  assign block_ready         = have_data;
  assign block_store_overrun = overflow;

  // one block in flight; flush drops it without a done
  always_ff @(posedge clk) begin
    block_done <= 1'b0;
    if (!rstn || block_flush) begin
      busy <= 1'b0;
      cnt  <= 8'h00;
    end else if (block_send) begin
      busy <= 1'b1;
      cnt  <= lat;
    end else if (busy && !xfer_hold) begin
      if (cnt == 8'h00) begin
        busy       <= 1'b0;
        block_done <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : tts_queue_model

//--- sim/test_transfer_trigger_and_status.sv
// Purpose: self-checking bench for the transfer trigger and status block
// Assumes: apb3 register map and codes from tts_pkg
// Notes:   burst start type is used for the source table, it has no state effect
`timescale 1ns/1ps
module test_transfer_trigger_and_status
  import tts_pkg::*;
;
  typedef struct packed {
    logic       en;
    logic [4:0] origin;
    logic [2:0] qual;
    logic       from;
    logic       to;
    logic [3:0] exp;
  } tts_row_t;

  logic        clk, rstn, psel, penable, pwrite, err;
  logic [7:0]  paddr, trig_event, lat;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, block_ready, block_done, block_store_overrun;
  logic        block_send, xfer_hold, block_flush, xfer_state_flag, have_data, overflow;
  logic [27:0] src_v;
  tts_flags_t  status_flags;
  int          n_fail = 0, num_checks = 0, n_send = 0, n_flush = 0, c, b, n0;
  tts_row_t    rows [14];

  tts_top dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src_v), .block_ready(block_ready), .block_done(block_done),
    .block_store_overrun(block_store_overrun), .block_send(block_send), .xfer_hold(xfer_hold),
    .block_flush(block_flush), .trig_event(trig_event), .status_flags(status_flags),
    .xfer_state_flag(xfer_state_flag));

  tts_queue_model far_u (.clk(clk), .rstn(rstn), .block_send(block_send), .xfer_hold(xfer_hold),
    .block_flush(block_flush), .have_data(have_data), .overflow(overflow), .lat(lat),
    .block_ready(block_ready), .block_done(block_done), .block_store_overrun(block_store_overrun));

  // clock and pulse counters
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (block_send === 1'b1) n_send <= n_send + 1;
    if (block_flush === 1'b1) n_flush <= n_flush + 1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; a dead slave is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task cfg(input logic [2:0] t, input logic en, input logic [4:0] o, input logic [2:0] q);
    apb(1'b1, OFS_TYPE_SEL, {29'h0, t});
    apb(1'b1, OFS_TRIG_CFG, {13'h0, q, 3'h0, o, 7'h0, en});
  endtask : cfg

  task hits(input int bit_i, input int cyc);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (trig_event[bit_i] === 1'b1) c++;
    end
  endtask : hits

  task wait_send(input int base);
    int n;
    n = 0;
    while (n_send <= base && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n_send > base}, 32'h1);
  endtask : wait_send

  task results;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // watchdog, far beyond the expected run
  initial begin
    #500000;
    n_fail++;
    results();
  end

  initial begin
    rows = '{
      '{1'b1, 5'd0,  QUAL_RISE, 1'b0, 1'b1, 4'h1},  // io pin, rising
      '{1'b1, 5'd0,  QUAL_RISE, 1'b1, 1'b0, 4'h0},  // rising ignores fall
      '{1'b1, 5'd1,  QUAL_FALL, 1'b0, 1'b1, 4'h0},  // falling ignores rise
      '{1'b1, 5'd2,  QUAL_FALL, 1'b1, 1'b0, 4'h1},
      '{1'b1, 5'd3,  QUAL_BOTH, 1'b1, 1'b0, 4'h1},
      '{1'b1, 5'd5,  QUAL_BOTH, 1'b0, 1'b1, 4'h1},  // counter begin
      '{1'b1, 5'd10, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // counter finish
      '{1'b1, 5'd12, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // timer begin
      '{1'b1, 5'd19, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // timer finish
      '{1'b1, 5'd21, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // logic block
      '{1'b1, 5'd25, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // software pulse
      '{1'b1, 5'd31, QUAL_RISE, 1'b0, 1'b1, 4'h1},  // action command
      '{1'b0, 5'd0,  QUAL_RISE, 1'b0, 1'b1, 4'h0},  // disabled
      '{1'b1, 5'd4,  QUAL_HIGH, 1'b0, 1'b1, 4'h1}}; // level code kept as rise
    {psel, penable, pwrite, paddr, pwdata, src_v} = '0;
    {have_data, overflow} = 2'b00;
    lat = 8'd12;
    rstn = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({27'h0, status_flags}, 32'h02);
    apb(1'b0, OFS_STATE, 32'h0);
    chk(rd, 32'h0000_0200);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    // source table, one row at a time
    foreach (rows[i]) begin
      b = (rows[i].origin >= 5'd24) ? rows[i].origin - 4 : rows[i].origin;
      if (rows[i].origin[4:2] != 3'd6) src_v[b] <= rows[i].from;
      repeat (5) @(posedge clk);
      cfg(TYP_BURST_GO, rows[i].en, rows[i].origin, rows[i].qual);
      repeat (5) @(posedge clk);
      if (rows[i].origin[4:2] == 3'd6)
        apb(1'b1, OFS_HOST_PULSE, 32'h1 << rows[i].origin[1:0]);
      else
        src_v[b] <= rows[i].to;
      hits(6, 8);
      chk(c, {28'h0, rows[i].exp});
      src_v[b] <= 1'b0;
      @(posedge clk); // keeps the next row's first drive off this time step
    end
    apb(1'b0, OFS_TRIG_CFG, 32'h0);
    chk(rd, 32'h0000_0401);
    // level modes on the activate type
    cfg(TYP_ACTIVATE, 1'b1, 5'd1, QUAL_HIGH);
    src_v[1] <= 1'b1;
    repeat (4) @(posedge clk);
    hits(5, 8);
    chk(c, 8);
    src_v[1] <= 1'b0;
    repeat (4) @(posedge clk);
    hits(5, 8);
    chk(c, 0);
    cfg(TYP_ACTIVATE, 1'b1, 5'd1, QUAL_LOW);
    @(posedge clk); // new mode reaches trig_event one edge after the write
    hits(5, 8);
    chk(c, 8);
    src_v[1] <= 1'b1;
    repeat (4) @(posedge clk);
    hits(5, 8);
    chk(c, 0);
    cfg(TYP_ACTIVATE, 1'b0, 5'd1, QUAL_RISE);
    src_v[1] <= 1'b0;
    // stream, then stop with a block in flight
    have_data <= 1'b1;
    apb(1'b1, OFS_CMD, 32'h1 << CMD_START);
    wait_send(0);
    chk({31'h0, n_send > 0}, 32'h1);
    n0 = n_send;
    apb(1'b1, OFS_CMD, 32'h1 << CMD_STOP);
    repeat (2) @(posedge clk);
    chk({27'h0, status_flags}, 32'h04);
    repeat (30) @(posedge clk);
    chk({27'h0, status_flags}, 32'h02);
    chk(n_send, n0);
    // pause freezes the block in flight, resume goes on
    apb(1'b1, OFS_CMD, 32'h1 << CMD_START);
    wait_send(n0);
    n0 = n_send;
    apb(1'b1, OFS_CMD, 32'h1 << CMD_PAUSE);
    repeat (2) @(posedge clk);
    chk({26'h0, xfer_hold, status_flags}, 32'h28);
    repeat (30) @(posedge clk);
    chk(n_send, n0);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_RESUME);
    wait_send(n0);
    chk({26'h0, xfer_hold, status_flags}, 32'h10);
    // abort drops the block at once
    apb(1'b1, OFS_CMD, 32'h1 << CMD_ABORT);
    repeat (3) @(posedge clk); // flush pulse is counted one edge after it shows
    chk({27'h0, status_flags}, 32'h02);
    chk(n_flush, 1);
    have_data <= 1'b0;
    // level pause holds the transfer only while its source stays high
    cfg(TYP_PAUSE, 1'b1, 5'd2, QUAL_HIGH);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_START);
    src_v[2] <= 1'b1;
    repeat (5) @(posedge clk);
    chk({26'h0, xfer_hold, status_flags}, 32'h28);
    src_v[2] <= 1'b0;
    repeat (5) @(posedge clk);
    chk({26'h0, xfer_hold, status_flags}, 32'h10);
    cfg(TYP_PAUSE, 1'b0, 5'd2, QUAL_RISE);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_STOP);
    // every query code in the stopped state
    for (int q = 0; q < 4; q++) begin
      apb(1'b1, OFS_QUERY_SEL, q);
      repeat (2) @(posedge clk);
      chk({31'h0, xfer_state_flag}, {31'h0, q == 3});
    end
    apb(1'b1, OFS_QUERY_SEL, {29'h0, QRY_OVERRUN});
    overflow <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, xfer_state_flag}, 32'h1);
    apb(1'b0, OFS_STATE, 32'h0);
    chk(rd, 32'h0000_0301);
    overflow <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, xfer_state_flag}, 32'h0);
    results();
  end
endmodule : test_transfer_trigger_and_status
